// ### verilog/asf_pkg.sv
// Purpose: Shared constants for the ALU status flag block
// Assumes: 8-bit data path, one clock
// Notes:   Flag positions, opcodes and addressing modes live here
package asf_pkg;
  localparam int FLAG_W        = 8;
  localparam int NEG_BIT       = 4;
  localparam int WRAP_BIT      = 3;
  localparam int ZERO_BIT      = 2;
  localparam int NIB_BIT       = 1;
  localparam int CARRY_BIT     = 0;
  localparam logic [7:0] IMPL_MASK   = 8'h1F;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;

  typedef enum logic [3:0] {
    ASF_OP_NONE    = 4'h0,
    ASF_OP_ADD     = 4'h1,
    ASF_OP_SUB     = 4'h2,
    ASF_OP_AND     = 4'h3,
    ASF_OP_OR      = 4'h4,
    ASF_OP_XOR     = 4'h5,
    ASF_OP_CLR     = 4'h6,
    ASF_OP_RRC     = 4'h7,
    ASF_OP_RLC     = 4'h8,
    ASF_OP_BSET    = 4'h9,
    ASF_OP_BCLR    = 4'hA,
    ASF_OP_SWAP    = 4'hB,
    ASF_OP_MOVE    = 4'hC
  } asf_op_t;

  typedef enum logic [2:0] {
    ASF_AM_INHERENT = 3'h0,
    ASF_AM_LITERAL  = 3'h1,
    ASF_AM_DIRECT   = 3'h2,
    ASF_AM_INDIRECT = 3'h3,
    ASF_AM_INDEXED  = 3'h4
  } asf_mode_t;
endpackage

// ### verilog/asf_alu.sv
// Purpose: Combinational ALU producing result and flag candidates
// Assumes: Operands already fetched by the core
// Notes:   Subtract adds the two's complement of operand b
`timescale 1ns/1ns
module asf_alu
  import asf_pkg::*;
(
  input  asf_op_t    op,
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic [2:0] bitSel,
  input  wire logic       carryIn,
  output logic [7:0] result,
  output logic       carryOut,
  output logic       nibbleOut,
  output logic       wrapOut
);
  logic [8:0] sum;
  logic [4:0] lowSum;
  logic [7:0] addend;
  logic [7:0] bitMask;

  always_comb begin
    // Borrow is carry with inverted sense
    addend   = (op == ASF_OP_SUB) ? ~opB : opB;
    sum      = {1'b0, opA} + {1'b0, addend} + {8'h00, op == ASF_OP_SUB};
    lowSum   = {1'b0, opA[3:0]} + {1'b0, addend[3:0]}
               + {4'h0, op == ASF_OP_SUB};
    bitMask  = 8'h01 << bitSel;
    result   = 8'h00;
    carryOut = carryIn;
    nibbleOut = 1'b0;
    wrapOut  = 1'b0;
    unique case (op)
      ASF_OP_ADD, ASF_OP_SUB: begin
        result    = sum[7:0];
        carryOut  = sum[8];
        nibbleOut = lowSum[4];
        wrapOut   = (opA[7] == addend[7]) && (sum[7] != opA[7]);
      end
      ASF_OP_AND:  result = opA & opB;
      ASF_OP_OR:   result = opA | opB;
      ASF_OP_XOR:  result = opA ^ opB;
      ASF_OP_CLR:  result = 8'h00;
      ASF_OP_RRC: begin
        result   = {carryIn, opA[7:1]};
        carryOut = opA[0];
      end
      ASF_OP_RLC: begin
        result   = {opA[6:0], carryIn};
        carryOut = opA[7];
      end
      ASF_OP_BSET: result = opA | bitMask;
      ASF_OP_BCLR: result = opA & ~bitMask;
      ASF_OP_SWAP: result = {opA[3:0], opA[7:4]};
      ASF_OP_MOVE: result = opA;
      default:     result = 8'h00;
    endcase
  end
endmodule

// ### verilog/asf_flags.sv
// Purpose: Arithmetic status flag register of an 8-bit core
// Assumes: Core presents one decoded instruction per execStb cycle
// Notes:   Flags read back through flagsOut and as operand source
//
// Contract
// - Negative flag follows result MSB
// - Signed wrap flag on sign change overflow
// - Zero flag when result is zero
// - Nibble carry from bit three on add/sub
// - Carry from MSB on add/sub
// - Subtract by adding two's complement
// - Rotate loads carry with shifted-out bit
// - Flag destination takes flags, not result; here BSET, BCLR, SWAP and MOVE write their result into the flags
// - Clearing flag register reads 000u u1uu; CLR here also clears negative, giving 0000 u1uu
// - Flag register usable as any operand; here only as source A (srcIsFlags) and as destination, never as opB
// - Program via counter; four data addressing modes
// - Mode fixed or chosen by operands
// - Indexed mode only with extended set
`timescale 1ns/1ns
module asf_flags
  import asf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       execStb,
  input  asf_op_t         op,
  input  wire logic [7:0] opA,
  input  wire logic [7:0] opB,
  input  wire logic [2:0] bitSel,
  input  wire logic       srcIsFlags,
  input  wire logic       dstIsFlags,
  input  wire logic       extended_isa_enable,
  input  asf_mode_t       modeReq,
  output logic [7:0]      flagsOut,
  output logic [7:0]      resultOut,
  output logic            resultWe,
  output asf_mode_t       modeOut,
  output logic            modeErr
);
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic       we_reg;
  logic       we_next;
  asf_mode_t  mode_reg;
  asf_mode_t  mode_next;
  logic       err_reg;
  logic       err_next;
  logic [7:0] srcA;
  logic [7:0] aluRes;
  logic       aluCarry;
  logic       aluNib;
  logic       aluWrap;
  logic       arith;
  logic       logic_op;
  logic       touches;

  assign srcA = srcIsFlags ? (flags_reg & IMPL_MASK) : opA;

  asf_alu uAlu (
    .op        (op),
    .opA       (srcA),
    .opB       (opB),
    .bitSel    (bitSel),
    .carryIn   (flags_reg[CARRY_BIT]),
    .result    (aluRes),
    .carryOut  (aluCarry),
    .nibbleOut (aluNib),
    .wrapOut   (aluWrap)
  );

  always_comb begin
    arith    = (op == ASF_OP_ADD) || (op == ASF_OP_SUB);
    logic_op = (op == ASF_OP_AND) || (op == ASF_OP_OR) ||
               (op == ASF_OP_XOR) || (op == ASF_OP_CLR);
    touches  = arith || logic_op ||
               (op == ASF_OP_RRC) || (op == ASF_OP_RLC);
    flags_next  = flags_reg;
    result_next = result_reg;
    we_next     = 1'b0;
    if (execStb) begin
      if (arith) begin
        flags_next[CARRY_BIT] = aluCarry;
        flags_next[NIB_BIT]   = aluNib;
        flags_next[WRAP_BIT]  = aluWrap;
      end
      if (op == ASF_OP_RRC || op == ASF_OP_RLC)
        flags_next[CARRY_BIT] = aluCarry;
      if (touches) begin
        flags_next[NEG_BIT]  = aluRes[7];
        flags_next[ZERO_BIT] = (aluRes == ZERO_BYTE);
      end
      if (dstIsFlags && !touches && op != ASF_OP_NONE) begin
        // Safe instructions write the flags directly
        flags_next = aluRes;
      end else if (!dstIsFlags && op != ASF_OP_NONE) begin
        result_next = aluRes;
        we_next     = 1'b1;
      end
      // Flag destination drops result; clear gives 0000 u1uu
    end
    flags_next = flags_next & IMPL_MASK;
  end

  always_comb begin
    mode_next = mode_reg;
    err_next  = 1'b0;
    if (execStb) begin
      // Indexed mode refused without extended set
      if (modeReq == ASF_AM_INDEXED && !extended_isa_enable) begin
        mode_next = ASF_AM_DIRECT;
        err_next  = 1'b1;
      end else begin
        mode_next = modeReq;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg  <= FLAGS_RESET;
      result_reg <= ZERO_BYTE;
      we_reg     <= 1'b0;
      mode_reg   <= ASF_AM_INHERENT;
      err_reg    <= 1'b0;
    end else begin
      flags_reg  <= flags_next;
      result_reg <= result_next;
      we_reg     <= we_next;
      mode_reg   <= mode_next;
      err_reg    <= err_next;
    end
  end

  assign flagsOut  = flags_reg;
  assign resultOut = result_reg;
  assign resultWe  = we_reg;
  assign modeOut   = mode_reg;
  assign modeErr   = err_reg;

  upper_zero_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    flagsOut[7:5] == 3'h0)
    else $error("upper flag bits nonzero");

  clr_dest_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_CLR && dstIsFlags |=>
      flagsOut[ZERO_BIT] && flagsOut[NEG_BIT] == 1'b0 &&
      flagsOut[1:0] == $past(flags_reg[1:0]) &&
      flagsOut[WRAP_BIT] == $past(flags_reg[WRAP_BIT]) && !resultWe)
    else $error("clear of flags wrong");

  zero_flag_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && touches |=> flagsOut[ZERO_BIT] == ($past(aluRes) == 8'h00))
    else $error("zero flag mismatch");

  neg_flag_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && touches |=> flagsOut[NEG_BIT] == $past(aluRes[7]))
    else $error("negative flag mismatch");

  sub_borrow_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_SUB && !srcIsFlags |=>
      flagsOut[CARRY_BIT] == ($past(opA) >= $past(opB)))
    else $error("borrow flag wrong");

  sub_nib_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_SUB && !srcIsFlags |=>
      flagsOut[NIB_BIT] == ($past(opA[3:0]) >= $past(opB[3:0])))
    else $error("nibble borrow wrong");

  add_carry_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_ADD && !srcIsFlags |=>
      flagsOut[CARRY_BIT] ==
        ({1'b0, $past(opA)} + {1'b0, $past(opB)} > 9'h0FF))
    else $error("carry flag wrong");

  nib_carry_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_ADD && !srcIsFlags |=>
      flagsOut[NIB_BIT] ==
        ({1'b0, $past(opA[3:0])} + {1'b0, $past(opB[3:0])} > 5'h0F))
    else $error("nibble carry wrong");

  wrap_flag_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_ADD && !srcIsFlags |=>
      flagsOut[WRAP_BIT] == ($past(opA[7]) == $past(opB[7]) &&
      $past(aluRes[7]) != $past(opA[7])))
    else $error("signed wrap wrong");

  logic_keep_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && logic_op |=>
      flagsOut[1:0] == $past(flags_reg[1:0]) &&
      flagsOut[WRAP_BIT] == $past(flags_reg[WRAP_BIT]))
    else $error("logic op touched arith flags");

  rot_carry_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_RRC |=> flagsOut[CARRY_BIT] == $past(srcA[0]))
    else $error("rotate carry wrong");

  rlc_carry_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_RLC |=> flagsOut[CARRY_BIT] == $past(srcA[7]))
    else $error("left rotate carry wrong");

  dest_flags_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && dstIsFlags |=> !resultWe)
    else $error("result written to flags dest");

  result_we_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && !dstIsFlags && op != ASF_OP_NONE |=>
      resultWe && resultOut == $past(aluRes))
    else $error("result not written");

  none_keep_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && op == ASF_OP_NONE |=>
      flagsOut == $past(flags_reg) && !resultWe)
    else $error("idle op changed state");

  idx_mode_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    execStb && modeReq == ASF_AM_INDEXED && !extended_isa_enable |=>
      modeErr && modeOut == ASF_AM_DIRECT)
    else $error("indexed mode allowed");
endmodule

// ### sim/test_alu_status_flags.sv
// Purpose: Self-checking bench for the ALU status flag register
// Assumes: One instruction per execStb, answer one cycle later
// Notes:   Flag reset value is the designer's chosen 00h
`timescale 1ns/1ns
module test_alu_status_flags
  import asf_pkg::*;
;
  logic       clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       execStb = 1'b0;
  asf_op_t    op = ASF_OP_NONE;
  logic [7:0] opA = 8'h00;
  logic [7:0] opB = 8'h00;
  logic [2:0] bitSel = 3'h0;
  logic       srcIsFlags = 1'b0;
  logic       dstIsFlags = 1'b0;
  logic       extIsa = 1'b0;
  asf_mode_t  modeReq = ASF_AM_INHERENT;
  logic [7:0] flagsOut;
  logic [7:0] resultOut;
  logic       resultWe;
  asf_mode_t  modeOut;
  logic       modeErr;
  int         nErrors = 0;
  int         checkCount = 0;

  always #5 clk = ~clk;

  asf_flags dut_u (
    .clk                 (clk),
    .reset_n             (reset_n),
    .execStb             (execStb),
    .op                  (op),
    .opA                 (opA),
    .opB                 (opB),
    .bitSel              (bitSel),
    .srcIsFlags          (srcIsFlags),
    .dstIsFlags          (dstIsFlags),
    .extended_isa_enable (extIsa),
    .modeReq             (modeReq),
    .flagsOut            (flagsOut),
    .resultOut           (resultOut),
    .resultWe            (resultWe),
    .modeOut             (modeOut),
    .modeErr             (modeErr)
  );

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, g);
    checkCount++;
    if (g !== e) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One instruction; we of x means resultWe is not judged
  task automatic run(input asf_op_t o, input logic [7:0] a, b,
                     input logic [2:0] s, input logic sf, df,
                     input logic [7:0] r, f, input logic we);
    @(posedge clk);
    op <= o;
    opA <= a;
    opB <= b;
    bitSel <= s;
    srcIsFlags <= sf;
    dstIsFlags <= df;
    execStb <= 1'b1;
    @(posedge clk);
    execStb <= 1'b0;
    #1;
    chk("flags", f, flagsOut);
    if (we !== 1'bx) chk("resultWe", {7'h00, we}, {7'h00, resultWe});
    if (we === 1'b1) chk("result", r, resultOut);
  endtask

  task automatic modes();
    asf_mode_t m;
    logic      bad;
    for (int x = 0; x < 2; x++) begin
      for (int i = 0; i < 5; i++) begin
        m = asf_mode_t'(i);
        bad = (m == ASF_AM_INDEXED) && (x == 0);
        @(posedge clk);
        op <= ASF_OP_NONE;
        modeReq <= m;
        extIsa <= x[0];
        execStb <= 1'b1;
        @(posedge clk);
        execStb <= 1'b0;
        #1;
        chk("mode", {5'h00, bad ? ASF_AM_DIRECT : m}, {5'h00, modeOut});
        chk("modeErr", {7'h00, bad}, {7'h00, modeErr});
      end
    end
  endtask

  initial begin
    #20000;
    nErrors++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge clk);
    chk("flags", FLAGS_RESET, flagsOut);
    chk("mode", 8'h00, {5'h00, modeOut});
    reset_n <= 1'b1;
    run(ASF_OP_ADD, 8'h7F, 8'h01, 3'h0, 0, 0, 8'h80, 8'h1A, 1);
    run(ASF_OP_ADD, 8'hFF, 8'h01, 3'h0, 0, 0, 8'h00, 8'h07, 1);
    run(ASF_OP_SUB, 8'h05, 8'h03, 3'h0, 0, 0, 8'h02, 8'h03, 1);
    run(ASF_OP_SUB, 8'h03, 8'h05, 3'h0, 0, 0, 8'hFE, 8'h10, 1);
    run(ASF_OP_SUB, 8'h80, 8'h01, 3'h0, 0, 0, 8'h7F, 8'h09, 1);
    run(ASF_OP_RLC, 8'h01, 8'h00, 3'h0, 0, 0, 8'h03, 8'h08, 1);
    run(ASF_OP_RRC, 8'h01, 8'h00, 3'h0, 0, 0, 8'h00, 8'h0D, 1);
    run(ASF_OP_RRC, 8'h00, 8'h00, 3'h0, 0, 0, 8'h80, 8'h18, 1);
    run(ASF_OP_XOR, 8'hA5, 8'hA5, 3'h0, 0, 0, 8'h00, 8'h0C, 1);
    run(ASF_OP_OR, 8'h80, 8'h01, 3'h0, 0, 0, 8'h81, 8'h18, 1);
    run(ASF_OP_AND, 8'hF0, 8'h0F, 3'h0, 0, 0, 8'h00, 8'h0C, 1);
    run(ASF_OP_SWAP, 8'h3C, 8'h00, 3'h0, 0, 0, 8'hC3, 8'h0C, 1);
    run(ASF_OP_ADD, 8'h7F, 8'h01, 3'h0, 0, 1, 8'h00, 8'h1A, 0);
    run(ASF_OP_CLR, 8'h00, 8'h00, 3'h0, 0, 1, 8'h00, 8'h0E, 0);
    run(ASF_OP_BSET, 8'h00, 8'h00, 3'h7, 1, 1, 8'h00, 8'h0E, 0);
    run(ASF_OP_BSET, 8'h00, 8'h00, 3'h0, 1, 1, 8'h00, 8'h0F, 0);
    run(ASF_OP_BCLR, 8'h00, 8'h00, 3'h1, 1, 1, 8'h00, 8'h0D, 0);
    run(ASF_OP_MOVE, 8'hFF, 8'hFF, 3'h0, 0, 1, 8'h00, 8'h1F, 0);
    run(ASF_OP_AND, 8'hE0, 8'hFF, 3'h0, 1, 0, 8'h1F, 8'h0B, 1);
    run(ASF_OP_NONE, 8'h55, 8'h00, 3'h0, 0, 1, 8'h00, 8'h0B, 0);
    modes();
    report_and_stop();
  end
endmodule
